// ===== src/aout_quad_diag_record.sv
// Purpose: Diagnostic data record of a four-channel analog output module,
//          with channel status indicators and a microsecond event stamp.
// Assumes: Fault inputs arrive from outside the clock domain; the
//          short-circuit enable byte comes from logic on this clock.
// Notes:   Reads answer one clock after the request; the record holds no
//          interrupt path at all.

`timescale 1ns/10ps

// How it works
// - No diagnostic interrupt exists; the record is only read.
// - A channel fault lights that channel's indicator and enters the record.
// - Record set 01h returns all bytes; 00h returns the first four.
// - CANopen index 2F01h returns all bytes; 2F00h the first four.
// - EtherCAT index 5005h, one subindex per byte 02h to 11h; the four stamp bytes share 13h.
// - Summary byte flags module, internal, external, channel, supply, parameters.
// - Module class byte reads 15h: analog class plus channel information.
// - Internal byte flags buffer overflow bit 3, communication bit 4.
// - Channel kind byte reads 73h, analog output.
// - Diagnostic bits per channel reads 08h.
// - Channel count reads 04h.
// - Group byte bit n flags a fault in channel group n.
// - Channel byte bit 0 configuration fault, bit 3 short to ground.
// - Short faults reported only on channels with detection enabled.
// - Timestamp field holds the microsecond count at the recorded event.
// - Microsecond counter starts at zero, counts each microsecond, wraps.
// - Enable byte bit n switches short detection on for channel n.
module aout_quad_diag_record #(
  parameter int unsigned N_CHAN = 4
) (
  input  wire logic              clk_in,             // 125 MHz clock.
  input  wire logic              rst_n_in,           // Async reset, low.
  input  wire logic              module_fail_in,     // Module failure.
  input  wire logic              ext_fault_in,       // External fault.
  input  wire logic              aux_missing_in,     // Aux supply missing.
  input  wire logic              param_fault_in,     // Module param fault.
  input  wire logic              diag_overflow_in,   // Diag buffer overflow.
  input  wire logic              comm_fault_in,      // Internal comm fault.
  input  wire logic [N_CHAN-1:0] chan_cfg_fault_in,  // Per-channel cfg fault.
  input  wire logic [N_CHAN-1:0] chan_short_in,      // Per-channel short.
  input  wire logic [7:0]        short_enable_in,    // Short detect enables.
  input  wire logic              rd_req_in,          // Read request pulse.
  input  wire logic [1:0]        rd_path_in,         // Access path.
  input  wire logic [15:0]       rd_index_in,        // Record no. or index.
  input  wire logic [7:0]        rd_subindex_in,     // EtherCAT subindex.
  input  wire logic [4:0]        rd_byte_in,         // Byte within access.
  output logic                   rd_ack_out,         // Read answer pulse.
  output logic                   rd_err_out,         // Read refused pulse.
  output logic [7:0]             rd_data_out,        // Read byte.
  output logic [N_CHAN-1:0]      chan_led_out,       // Channel fault LEDs.
  output logic [31:0]            us_ticker_out       // Running us counter.
);

  // ==========================================================================
  // Input synchronisers.
  localparam int unsigned N_ASYNC = 6 + 2 * N_CHAN;

  logic [N_ASYNC-1:0] async_vec;
  logic [N_ASYNC-1:0] sync1_reg;
  logic [N_ASYNC-1:0] sync1_next;
  logic [N_ASYNC-1:0] sync2_reg;
  logic [N_ASYNC-1:0] sync2_next;

  assign async_vec = {module_fail_in, ext_fault_in, aux_missing_in,
                      param_fault_in, diag_overflow_in, comm_fault_in,
                      chan_cfg_fault_in, chan_short_in};

  // The first stage feeds only the second; all logic reads sync2_reg.
  always_comb begin
    sync1_next = async_vec;
    sync2_next = sync1_reg;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
    end
  end

  logic              s_module_fail;
  logic              s_ext_fault;
  logic              s_aux_missing;
  logic              s_param_fault;
  logic              s_overflow;
  logic              s_comm_fault;
  logic [N_CHAN-1:0] s_cfg_fault;
  logic [N_CHAN-1:0] s_short;

  assign {s_module_fail, s_ext_fault, s_aux_missing, s_param_fault,
          s_overflow, s_comm_fault, s_cfg_fault, s_short} = sync2_reg;

  // ==========================================================================
  // Microsecond ticker.
  logic [7:0]  presc_reg;
  logic [7:0]  presc_next;
  logic [31:0] ticker_reg;
  logic [31:0] ticker_next;

  // The 32-bit add wraps to zero on its own after the all-ones value.
  always_comb begin
    presc_next  = presc_reg + 8'h01;
    ticker_next = ticker_reg;
    if (presc_reg == aout_diag_pkg::TICK_LAST) begin
      presc_next  = 8'h00;
      ticker_next = ticker_reg + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      presc_reg  <= 8'h00;
      ticker_reg <= aout_diag_pkg::STAMP_RESET;
    end else begin
      presc_reg  <= presc_next;
      ticker_reg <= ticker_next;
    end
  end

  assign us_ticker_out = ticker_reg;

  // ==========================================================================
  // Fault record.
  logic [7:0]        summary_reg;
  logic [7:0]        summary_next;
  logic [7:0]        internal_reg;
  logic [7:0]        internal_next;
  logic [7:0]        group_reg;
  logic [7:0]        group_next;
  logic [7:0]        chan_reg  [N_CHAN];
  logic [7:0]        chan_next [N_CHAN];
  logic [31:0]       stamp_reg;
  logic [31:0]       stamp_next;
  logic [N_CHAN-1:0] led_reg;
  logic [N_CHAN-1:0] led_next;
  logic [N_CHAN-1:0] chan_any;
  logic              record_changed;

  // Per-channel bytes; a short counts only where detection is enabled.
  for (genvar ch = 0; ch < N_CHAN; ch++) begin : g_chan
    always_comb begin
      chan_next[ch] = aout_diag_pkg::FAULT_RESET;
      chan_next[ch][aout_diag_pkg::CH_CONFIG] = s_cfg_fault[ch];
      chan_next[ch][aout_diag_pkg::CH_SHORT]  =
        s_short[ch] & short_enable_in[ch];
    end
  end

  // Group bits and indicators come from one process, so each vector has a
  // single driver; groups beyond the fitted channels read zero.
  always_comb begin
    for (int i = 0; i < N_CHAN; i++) begin
      chan_any[i] = |chan_next[i];
    end
    group_next = 8'(chan_any);
    led_next   = chan_any;
  end

  // Summary and internal bytes follow the channel bytes in the same cycle,
  // so a reader never sees a channel bit without its summary bit.
  always_comb begin
    internal_next = aout_diag_pkg::FAULT_RESET;
    internal_next[aout_diag_pkg::INT_OVERFLOW] = s_overflow;
    internal_next[aout_diag_pkg::INT_COMM]     = s_comm_fault;
    summary_next = aout_diag_pkg::FAULT_RESET;
    summary_next[aout_diag_pkg::SUM_MODULE_FAIL] = s_module_fail;
    summary_next[aout_diag_pkg::SUM_INTERNAL]    = |internal_next;
    summary_next[aout_diag_pkg::SUM_EXTERNAL]    =
      s_ext_fault | (|(s_short & short_enable_in[N_CHAN-1:0]));
    summary_next[aout_diag_pkg::SUM_CHANNEL]     = |chan_any;
    summary_next[aout_diag_pkg::SUM_AUX_MISSING] = s_aux_missing;
    summary_next[aout_diag_pkg::SUM_PARAM]       =
      s_param_fault | (|s_cfg_fault);
  end

  // A diagnostic event is any change of the recorded fault content.
  always_comb begin
    record_changed = (summary_next != summary_reg) ||
                     (internal_next != internal_reg) ||
                     (group_next != group_reg);
    for (int i = 0; i < N_CHAN; i++) begin
      if (chan_next[i] != chan_reg[i]) begin
        record_changed = 1'b1;
      end
    end
    stamp_next = stamp_reg;
    if (record_changed) begin
      stamp_next = ticker_reg;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      summary_reg  <= aout_diag_pkg::FAULT_RESET;
      internal_reg <= aout_diag_pkg::FAULT_RESET;
      group_reg    <= aout_diag_pkg::FAULT_RESET;
      stamp_reg    <= aout_diag_pkg::STAMP_RESET;
      led_reg      <= '0;
      for (int i = 0; i < N_CHAN; i++) begin
        chan_reg[i] <= aout_diag_pkg::FAULT_RESET;
      end
    end else begin
      summary_reg  <= summary_next;
      internal_reg <= internal_next;
      group_reg    <= group_next;
      stamp_reg    <= stamp_next;
      led_reg      <= led_next;
      for (int i = 0; i < N_CHAN; i++) begin
        chan_reg[i] <= chan_next[i];
      end
    end
  end

  assign chan_led_out = led_reg;

  // ==========================================================================
  // Record byte lookup.
  localparam int unsigned CH_IDX_W = (N_CHAN > 1) ? $clog2(N_CHAN) : 1;

  logic [7:0] rec_byte;
  logic [4:0] rec_ofs;
  logic [4:0] chan_ofs;

  // Unfitted channel bytes and the reserved byte read as zero.
  always_comb begin
    rec_byte = 8'h00;
    chan_ofs = rec_ofs - aout_diag_pkg::OFS_CHAN0_FAULT;
    case (rec_ofs)
      aout_diag_pkg::OFS_FAULT_SUMMARY: rec_byte = summary_reg;
      aout_diag_pkg::OFS_MODULE_CLASS:
        rec_byte = aout_diag_pkg::MODULE_CLASS_VAL;
      aout_diag_pkg::OFS_RESERVED: rec_byte = 8'h00;
      aout_diag_pkg::OFS_INTERNAL: rec_byte = internal_reg;
      aout_diag_pkg::OFS_CHANNEL_KIND:
        rec_byte = aout_diag_pkg::CHANNEL_KIND_VAL;
      aout_diag_pkg::OFS_BITS_PER_CHAN:
        rec_byte = aout_diag_pkg::BITS_PER_CHAN_VAL;
      aout_diag_pkg::OFS_CHANNEL_COUNT:
        rec_byte = aout_diag_pkg::CHANNEL_COUNT_VAL;
      aout_diag_pkg::OFS_GROUP_FAULT: rec_byte = group_reg;
      default: begin
        if (rec_ofs >= aout_diag_pkg::OFS_TIMESTAMP) begin
          rec_byte = stamp_reg[8*rec_ofs[1:0] +: 8];
        end else if (chan_ofs < 5'(N_CHAN)) begin
          rec_byte = chan_reg[CH_IDX_W'(chan_ofs)];
        end
      end
    endcase
  end

  // ==========================================================================
  // Access decode and answer.
  logic       hit;
  logic       ack_reg;
  logic       ack_next;
  logic       err_reg;
  logic       err_next;
  logic [7:0] data_reg;
  logic [7:0] data_next;

  // Pure read port: no access has a side effect, and nothing raises an
  // interrupt; the reader polls the record instead.
  always_comb begin
    hit     = 1'b0;
    rec_ofs = rd_byte_in;
    case (rd_path_in)
      aout_diag_pkg::PATH_RECORD_SET: begin
        if (rd_index_in == aout_diag_pkg::RS_FULL) begin
          hit = rd_byte_in < aout_diag_pkg::RECORD_LEN;
        end else if (rd_index_in == aout_diag_pkg::RS_SHORT) begin
          hit = rd_byte_in < aout_diag_pkg::SHORT_RECORD_LEN;
        end
      end
      aout_diag_pkg::PATH_CANOPEN: begin
        if (rd_index_in == aout_diag_pkg::CO_FULL) begin
          hit = rd_byte_in < aout_diag_pkg::RECORD_LEN;
        end else if (rd_index_in == aout_diag_pkg::CO_SHORT) begin
          hit = rd_byte_in < aout_diag_pkg::SHORT_RECORD_LEN;
        end
      end
      aout_diag_pkg::PATH_ETHERCAT: begin
        if (rd_index_in == aout_diag_pkg::EC_INDEX) begin
          if (rd_subindex_in == aout_diag_pkg::EC_SUB_STAMP) begin
            hit     = rd_byte_in < 5'h04;
            rec_ofs = aout_diag_pkg::OFS_TIMESTAMP + {3'b000, rd_byte_in[1:0]};
          end else if (rd_subindex_in >= aout_diag_pkg::EC_SUB_FIRST &&
                       rd_subindex_in <= aout_diag_pkg::EC_SUB_LAST) begin
            hit     = rd_byte_in == 5'h00;
            rec_ofs = 5'(rd_subindex_in - aout_diag_pkg::EC_SUB_FIRST);
          end
        end
      end
      default: hit = 1'b0;
    endcase
    ack_next  = rd_req_in & hit;
    err_next  = rd_req_in & ~hit;
    data_next = hit ? rec_byte : 8'h00;
    if (!rd_req_in) begin
      data_next = data_reg;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_reg  <= 1'b0;
      err_reg  <= 1'b0;
      data_reg <= 8'h00;
    end else begin
      ack_reg  <= ack_next;
      err_reg  <= err_next;
      data_reg <= data_next;
    end
  end

  assign rd_ack_out  = ack_reg;
  assign rd_err_out  = err_reg;
  assign rd_data_out = data_reg;

endmodule

// ===== pkg/aout_diag_pkg.sv
// Purpose: Shared constants for the four-channel analog output diagnostic
//          record: byte layout, constant field values, access keys, timing.
// Assumes: Record bytes are numbered from 0 in the order they are returned.
// Notes:   The timestamp is returned least significant byte first.

package aout_diag_pkg;

  // ==========================================================================
  // Clock and microsecond ticker timing.
  localparam int unsigned CLK_PERIOD_PS = 8000;
  localparam int unsigned TICK_TIME_US  = 1;
  localparam int unsigned TICK_CYCLES   =
    (TICK_TIME_US * 1000000) / CLK_PERIOD_PS;
  localparam logic [7:0]  TICK_LAST     = 8'(TICK_CYCLES - 1);

  // ==========================================================================
  // Record byte offsets.
  localparam logic [4:0] OFS_FAULT_SUMMARY = 5'h00;
  localparam logic [4:0] OFS_MODULE_CLASS  = 5'h01;
  localparam logic [4:0] OFS_RESERVED      = 5'h02;
  localparam logic [4:0] OFS_INTERNAL      = 5'h03;
  localparam logic [4:0] OFS_CHANNEL_KIND  = 5'h04;
  localparam logic [4:0] OFS_BITS_PER_CHAN = 5'h05;
  localparam logic [4:0] OFS_CHANNEL_COUNT = 5'h06;
  localparam logic [4:0] OFS_GROUP_FAULT   = 5'h07;
  localparam logic [4:0] OFS_CHAN0_FAULT   = 5'h08;
  localparam logic [4:0] OFS_TIMESTAMP     = 5'h10;
  localparam logic [4:0] RECORD_LEN        = 5'h14;
  localparam logic [4:0] SHORT_RECORD_LEN  = 5'h04;

  // ==========================================================================
  // Constant record contents and reset values.
  localparam logic [7:0] MODULE_CLASS_VAL  = 8'h15;
  localparam logic [7:0] CHANNEL_KIND_VAL  = 8'h73;
  localparam logic [7:0] BITS_PER_CHAN_VAL = 8'h08;
  localparam logic [7:0] CHANNEL_COUNT_VAL = 8'h04;
  localparam logic [7:0] FAULT_RESET       = 8'h00;
  localparam logic [31:0] STAMP_RESET      = 32'h0000_0000;

  // ==========================================================================
  // Bit positions.
  localparam int unsigned SUM_MODULE_FAIL = 0;
  localparam int unsigned SUM_INTERNAL    = 1;
  localparam int unsigned SUM_EXTERNAL    = 2;
  localparam int unsigned SUM_CHANNEL     = 3;
  localparam int unsigned SUM_AUX_MISSING = 4;
  localparam int unsigned SUM_PARAM       = 7;
  localparam int unsigned INT_OVERFLOW    = 3;
  localparam int unsigned INT_COMM        = 4;
  localparam int unsigned CH_CONFIG       = 0;
  localparam int unsigned CH_SHORT        = 3;

  // ==========================================================================
  // Access paths and keys.
  typedef enum logic [1:0] {
    PATH_RECORD_SET = 2'b00,
    PATH_CANOPEN    = 2'b01,
    PATH_ETHERCAT   = 2'b10
  } access_path_e;

  localparam logic [15:0] RS_FULL       = 16'h0001;
  localparam logic [15:0] RS_SHORT      = 16'h0000;
  localparam logic [15:0] CO_FULL       = 16'h2f01;
  localparam logic [15:0] CO_SHORT      = 16'h2f00;
  localparam logic [15:0] EC_INDEX      = 16'h5005;
  localparam logic [7:0]  EC_SUB_FIRST  = 8'h02;
  localparam logic [7:0]  EC_SUB_LAST   = 8'h11;
  localparam logic [7:0]  EC_SUB_STAMP  = 8'h13;

endpackage

// ===== verif/aout_diag_monitor.sv
// Purpose: Port checker for the diagnostic record block.
// Assumes: One clock domain and an asynchronous active-low reset.
// Notes:   Bound to every instance of the record block.
`timescale 1ns/10ps
module aout_diag_monitor #(
  parameter int unsigned N_CHAN = 4
) (
  input wire logic              clk_in,            // Clock.
  input wire logic              rst_n_in,          // Reset, low.
  input wire logic [N_CHAN-1:0] chan_cfg_fault_in, // Config faults.
  input wire logic              rd_req_in,         // Read request.
  input wire logic [1:0]        rd_path_in,        // Access path.
  input wire logic [15:0]       rd_index_in,       // Index.
  input wire logic [7:0]        rd_subindex_in,    // Subindex.
  input wire logic [4:0]        rd_byte_in,        // Byte offset.
  input wire logic              rd_ack_out,        // Answer.
  input wire logic              rd_err_out,        // Refusal.
  input wire logic [7:0]        rd_data_out,       // Read byte.
  input wire logic [N_CHAN-1:0] chan_led_out,      // Channel LEDs.
  input wire logic [31:0]       us_ticker_out      // Ticker.
);
  // ==========================================================================
  // Helper logic
  // Cycles since the ticker moved; a stalled ticker shows up here.
  logic [7:0]  gap_reg;
  logic [7:0]  gap_next;
  logic [31:0] prev_reg;
  always_comb begin
    gap_next = (us_ticker_out != prev_reg) ? 8'h00 : gap_reg + 8'h01;
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gap_reg  <= 8'h00;
      prev_reg <= 32'h0;
    end else begin
      gap_reg  <= gap_next;
      prev_reg <= us_ticker_out;
    end
  end

  // Fixed record contents by byte offset.
  function automatic logic [7:0] fixed_byte(input logic [4:0] b);
    case (b)
      5'h01:   return 8'h15;
      5'h04:   return 8'h73;
      5'h05:   return 8'h08;
      default: return 8'h04;
    endcase
  endfunction

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  one_answer_a: assert property (
    rd_req_in |=> rd_ack_out != rd_err_out)
    else $error("Read not answered by exactly one pulse.");
  no_unasked_a: assert property (
    !rd_req_in |=> !rd_ack_out && !rd_err_out)
    else $error("Answer pulse without a request.");
  bad_path_a: assert property (
    rd_req_in && rd_path_in == 2'h3 |=> rd_err_out && rd_data_out == 8'h00)
    else $error("Unknown path not refused.");
  short_rec_a: assert property (
    rd_req_in && rd_path_in == 2'h0 && rd_index_in == 16'h0000
    && rd_byte_in > 5'h03 |=> rd_err_out)
    else $error("Short record read past byte 3.");
  co_len_a: assert property (
    rd_req_in && rd_path_in == 2'h1 && rd_byte_in > 5'h13 |=> rd_err_out)
    else $error("Object read past byte 19.");
  ec_gap_a: assert property (
    rd_req_in && rd_path_in == 2'h2 && rd_subindex_in == 8'h12
    |=> rd_err_out)
    else $error("Unused subindex not refused.");
  fixed_byte_a: assert property (
    rd_req_in && rd_path_in == 2'h0 && rd_index_in == 16'h0001
    && rd_byte_in inside {5'h01, 5'h04, 5'h05, 5'h06}
    |=> rd_data_out == fixed_byte($past(rd_byte_in)))
    else $error("Fixed record byte wrong.");
  led_on_a: assert property (
    chan_cfg_fault_in[0] [*4] |=> chan_led_out[0])
    else $error("Channel LED not lit on fault.");
  tick_step_a: assert property (
    us_ticker_out != $past(us_ticker_out)
    |-> us_ticker_out == $past(us_ticker_out) + 32'h1)
    else $error("Ticker moved by other than one.");
  tick_gap_a: assert property (gap_reg <= 8'h7d)
    else $error("Ticker stalled beyond one microsecond.");
endmodule

bind aout_quad_diag_record aout_diag_monitor #(.N_CHAN(N_CHAN)) i_mon (
  .clk_in(clk_in), .rst_n_in(rst_n_in),
  .chan_cfg_fault_in(chan_cfg_fault_in), .rd_req_in(rd_req_in),
  .rd_path_in(rd_path_in), .rd_index_in(rd_index_in),
  .rd_subindex_in(rd_subindex_in), .rd_byte_in(rd_byte_in),
  .rd_ack_out(rd_ack_out), .rd_err_out(rd_err_out),
  .rd_data_out(rd_data_out), .chan_led_out(chan_led_out),
  .us_ticker_out(us_ticker_out));

// ===== verif/coupler_reader.sv
// Purpose: Bus coupler model that reads diagnostic record bytes.
// Assumes: The record answers one clock after the request edge.
// Notes:   Released index, subindex and byte fields are scrambled so stale values never help.
`timescale 1ns/10ps
module coupler_reader (
  input  wire logic        clk_in,    // Clock.
  input  wire logic        ack_in,    // Answer pulse.
  input  wire logic        err_in,    // Refusal pulse.
  input  wire logic [7:0]  data_in,   // Read byte.
  output logic             req_out,   // Request pulse.
  output logic [1:0]       path_out,  // Access path.
  output logic [15:0]      index_out, // Record number or index.
  output logic [7:0]       sub_out,   // Subindex.
  output logic [4:0]       byte_out   // Byte offset.
);
  initial begin
    req_out   = 1'b0;
    path_out  = 2'h3;
    index_out = 16'h0;
    sub_out   = 8'h0;
    byte_out  = 5'h0;
  end

  // One request; an idle edge first so strobes never toggle twice at once.
  task automatic fetch(input logic [1:0] p, input logic [15:0] ix,
                       input logic [7:0] sx, input logic [4:0] b,
                       output logic [7:0] d, output logic ok);
    @(posedge clk_in);
    #1;
    req_out   = 1'b1;
    path_out  = p;
    index_out = ix;
    sub_out   = sx;
    byte_out  = b;
    @(posedge clk_in);
    #1;
    d         = data_in;
    ok        = ack_in && !err_in;
    req_out   = 1'b0;
    index_out = ~ix;
    sub_out   = ~sx;
    byte_out  = ~b;
  endtask
endmodule

// ===== verif/test_aout_quad_diag_record.sv
// Purpose: Self-checking bench for the diagnostic record block.
// Assumes: Faults are held steady while a record is read.
// Notes:   Stamp and ticker are checked within one microsecond.
`timescale 1ns/10ps
module test_aout_quad_diag_record;
  logic        clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        mf = 1'b0, ext = 1'b0, aux = 1'b0;
  logic        prm = 1'b0, ovf = 1'b0, comm = 1'b0;
  logic [3:0]  cfg = 4'h0, shrt = 4'h0, led;
  logic [7:0]  en = 8'h00, sub, data;
  logic        req, ack, err;
  logic [1:0]  path;
  logic [15:0] idx;
  logic [4:0]  bsel;
  logic [31:0] tick;
  logic [7:0]  d;
  integer      seed = 32'hc036d006;
  int          num_errors = 0, tests_run = 0, cyc = 0, exp_us = 0;
  int          exp_rec[16], old_rec[16];

  always #4 clk_in = ~clk_in;
  always @(posedge clk_in) cyc <= rst_n_in ? cyc + 1 : 0;

  aout_quad_diag_record i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .module_fail_in(mf), .ext_fault_in(ext), .aux_missing_in(aux),
    .param_fault_in(prm), .diag_overflow_in(ovf), .comm_fault_in(comm),
    .chan_cfg_fault_in(cfg), .chan_short_in(shrt), .short_enable_in(en),
    .rd_req_in(req), .rd_path_in(path), .rd_index_in(idx),
    .rd_subindex_in(sub), .rd_byte_in(bsel), .rd_ack_out(ack),
    .rd_err_out(err), .rd_data_out(data), .chan_led_out(led),
    .us_ticker_out(tick));
  coupler_reader i_reader (.clk_in(clk_in), .ack_in(ack), .err_in(err),
    .data_in(data), .req_out(req), .path_out(path), .index_out(idx),
    .sub_out(sub), .byte_out(bsel));

  // ==========================================================================
  // Model of record bytes 0 to 15 from the fault inputs.
  function automatic void build();
    int ch;
    exp_rec = '{default: 0};
    exp_rec[1] = 'h15;
    exp_rec[4] = 'h73;
    exp_rec[5] = 'h08;
    exp_rec[6] = 'h04;
    exp_rec[3] = (ovf << 3) | (comm << 4);
    for (int n = 0; n < 4; n++) begin
      ch = cfg[n] | ((shrt[n] & en[n]) << 3);
      exp_rec[8 + n] = ch;
      if (ch != 0) exp_rec[7] |= 1 << n;
    end
    exp_rec[0] = mf | ((exp_rec[3] != 0) << 1)
      | ((ext | (|(shrt & en[3:0]))) << 2) | ((exp_rec[7] != 0) << 3)
      | (aux << 4) | ((prm | (|cfg)) << 7);
  endfunction

  task automatic check(input string what, input int e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      $display("[ERR] %s expected %0h seen %0h", what, e, s);
      num_errors++;
    end
  endtask

  // One read; a negative expected byte skips the data comparison.
  task automatic probe(input logic [1:0] p, input logic [15:0] ix,
                       input logic [7:0] sx, input logic [4:0] b,
                       input logic ok_e, input int d_e);
    logic ok;
    i_reader.fetch(p, ix, sx, b, d, ok);
    check("read_ok", 32'(ok_e), 32'(ok));
    if (d_e >= 0) check("read_data", d_e, 32'(d));
  endtask

  // Whole record over one path, then stamp and ticker windows.
  task automatic read_all(input logic [1:0] p);
    logic [15:0] ix;
    logic [31:0] stamp;
    int          dif;
    ix = (p == 2'h0) ? 16'h0001 : (p == 2'h1) ? 16'h2f01 : 16'h5005;
    for (int b = 0; b < 20; b++) begin
      if (p != 2'h2) probe(p, ix, 8'h00, 5'(b), 1'b1, b < 16 ? exp_rec[b] : -1);
      else if (b < 16) probe(p, ix, 8'(b + 2), 5'h00, 1'b1, exp_rec[b]);
      else probe(p, ix, 8'h13, 5'(b - 16), 1'b1, -1);
      if (b >= 16) stamp[8 * (b - 16) +: 8] = d;
    end
    dif = int'(stamp) - exp_us;
    check("stamp_window", 1, 32'(dif >= -1 && dif <= 1));
    dif = int'(tick) - cyc / 125;
    check("ticker_window", 1, 32'(dif >= -1 && dif <= 1));
  endtask

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ==========================================================================
  // Main sequence: defaults, every path, refusals, random faults.
  initial begin
    repeat (2) @(posedge clk_in);
    #1;
    rst_n_in = 1'b1;
    build();
    read_all(2'h0);
    read_all(2'h1);
    read_all(2'h2);
    probe(2'h0, 16'h0000, 8'h00, 5'h03, 1'b1, exp_rec[3]);
    probe(2'h0, 16'h0000, 8'h00, 5'h04, 1'b0, 0);
    probe(2'h0, 16'h0002, 8'h00, 5'h00, 1'b0, 0);
    probe(2'h3, 16'h0001, 8'h00, 5'h00, 1'b0, 0);
    probe(2'h1, 16'h2f00, 8'h00, 5'h00, 1'b1, exp_rec[0]);
    probe(2'h1, 16'h2f00, 8'h00, 5'h04, 1'b0, 0);
    probe(2'h1, 16'h2f02, 8'h00, 5'h00, 1'b0, 0);
    probe(2'h1, 16'h2f01, 8'h00, 5'h14, 1'b0, 0);
    probe(2'h2, 16'h5005, 8'h12, 5'h00, 1'b0, 0);
    probe(2'h2, 16'h5005, 8'h13, 5'h04, 1'b0, 0);
    probe(2'h2, 16'h5006, 8'h02, 5'h00, 1'b0, 0);
    for (int i = 0; i < 12; i++) begin
      old_rec = exp_rec;
      {mf, ext, aux, prm, ovf, comm} = (i % 11 == 0) ? 6'h0 : 6'($random(seed));
      cfg  = (i % 11 == 0) ? 4'h0 : 4'($random(seed));
      shrt = (i == 11) ? 4'h0 : (i == 0) ? 4'hf : 4'($random(seed));
      // The enable byte skips the synchroniser, so it changes two clocks
      // later to meet the synchronised faults in one record update.
      repeat (2) @(posedge clk_in);
      #1;
      en   = (i == 0) ? 8'hf0 : 8'($random(seed));
      build();
      if (exp_rec != old_rec) exp_us = cyc / 125;
      repeat (5) @(posedge clk_in);
      #1;
      check("leds", exp_rec[7], 32'(led));
      read_all(2'(i % 3));
    end
    final_report();
  end

  // Watchdog: a hang counts as a mismatch.
  initial begin
    repeat (40000) @(posedge clk_in);
    num_errors++;
    final_report();
  end
endmodule
